// file: rtl/dcft_pkg.sv
package dcft_pkg;
	localparam logic [3:0] DCFT_ADDR_CLOCK_CONFIG = 4'h0;
	localparam logic [3:0] DCFT_ADDR_STEADY_STATE = 4'h4;
	localparam logic [3:0] DCFT_ADDR_TRANSITION   = 4'h8;
	localparam logic [3:0] DCFT_ADDR_STATUS       = 4'hc;
	localparam int DCFT_SRC_POS  = 6;
	localparam int DCFT_DIV_POS  = 4;
	localparam int DCFT_FDIV_POS = 0;
	localparam int DCFT_TIME_W   = 10;
	localparam logic [15:0] DCFT_CLOCK_CONFIG_MASK = 16'h00f7;
	localparam logic [15:0] DCFT_TIME_MASK         = 16'h03ff;
	localparam logic [7:0]  DCFT_CLOCK_CONFIG_RST  = 8'h00;
	localparam logic [9:0]  DCFT_STEADY_STATE_RST  = 10'h08a;
	localparam logic [9:0]  DCFT_TRANSITION_RST    = 10'h055;
	localparam logic [1:0]  DCFT_SRC_PLL      = 2'h3;
	localparam logic [1:0]  DCFT_SRC_VCO_DIV3 = 2'h2;
	localparam logic [1:0]  DCFT_SRC_VCO_DIV2 = 2'h1;
	localparam logic [1:0]  DCFT_SRC_VCO_DIVR = 2'h0;
	localparam logic [1:0]  DCFT_DIV_1X = 2'h0;
	localparam logic [1:0]  DCFT_DIV_2  = 2'h1;
	localparam logic [1:0]  DCFT_DIV_3  = 2'h2;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} dcft_bus_req_t;

	typedef struct packed {
		logic [1:0] source_select;
		logic [1:0] divider;
		logic [2:0] filter_divider;
		logic [9:0] steady_state_delay;
		logic [9:0] transition_duration;
	} dcft_cfg_t;

	typedef enum logic [1:0] {
		DCFT_IDLE       = 2'b00,
		DCFT_TRANSITION = 2'b01,
		DCFT_FAST       = 2'b11,
		DCFT_STEADY     = 2'b10
	} dcft_filt_state_t;

	// ratio minus one; returns zero for 1x
	function automatic logic [2:0] dcft_fdiv_ratio(input logic [2:0] code);
		dcft_fdiv_ratio = code;
	endfunction : dcft_fdiv_ratio
endpackage : dcft_pkg

// file: rtl/dcft_divider.sv
`timescale 1ns/1ps
`default_nettype none
module dcft_divider
	import dcft_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       en_in,
	input  wire logic [2:0] ratio_m1,
	output logic            en_out
);
	// ************************************
	// divide an enable train by ratio_m1+1
	// ************************************
	typedef struct packed {
		logic [2:0] cnt;
	} dcft_div_state_t;

	dcft_div_state_t st;
	dcft_div_state_t next_st;

	always_comb begin
		next_st = st;
		if (en_in) begin
			if (st.cnt >= ratio_m1) begin
				next_st.cnt = 3'h0;
			end else begin
				next_st.cnt = st.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign en_out = en_in && (st.cnt >= ratio_m1);
endmodule : dcft_divider
`default_nettype wire

// file: rtl/dcft_filter_seq.sv
`timescale 1ns/1ps
`default_nettype none
module dcft_filter_seq
	import dcft_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       tick,
	input  wire logic       start,
	input  wire logic [9:0] steady_state_delay,
	input  wire logic [9:0] transition_duration,
	output logic            transition_mode,
	output logic            steady_state_en,
	output logic [9:0]      elapsed
);
	// ************************************
	// rc filter mode sequencing
	// ************************************
	typedef struct packed {
		dcft_filt_state_t fs;
		logic [9:0]       cnt;
		logic             tm;
		logic             ss;
	} dcft_seq_state_t;

	dcft_seq_state_t st;
	dcft_seq_state_t next_st;

	always_comb begin
		next_st = st;
		if (start) begin
			next_st.fs  = DCFT_TRANSITION;
			next_st.cnt = 10'h000;
		end else if (tick) begin
			unique case (st.fs)
				DCFT_IDLE: begin
				end
				DCFT_TRANSITION: begin
					next_st.cnt = st.cnt + 10'h001;
					if (st.cnt + 10'h001 >= transition_duration) begin
						// both limits on one tick: go straight to steady so the delay stays exact
						if (st.cnt + 10'h001 >= steady_state_delay) begin
							next_st.fs = DCFT_STEADY;
						end else begin
							next_st.fs = DCFT_FAST;
						end
					end
				end
				DCFT_FAST: begin
					next_st.cnt = st.cnt + 10'h001;
					// delay counts from transition start, so keep counting
					if (st.cnt + 10'h001 >= steady_state_delay) begin
						next_st.fs = DCFT_STEADY;
					end
				end
				DCFT_STEADY: begin
				end
			endcase
		end
		next_st.tm = (next_st.fs == DCFT_TRANSITION);
		next_st.ss = (next_st.fs == DCFT_STEADY);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '{fs: DCFT_IDLE, cnt: 10'h000, tm: 1'b0, ss: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign transition_mode = st.tm;
	assign steady_state_en = st.ss;
	assign elapsed         = st.cnt;
endmodule : dcft_filter_seq
`default_nettype wire

// file: rtl/dcft_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcft_top
	import dcft_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        pll_output_clock,
	input  wire logic        vco_div3_clock,
	input  wire logic        vco_div2_clock,
	input  wire logic        vco_divider_clock,
	input  wire logic        filter_start,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [15:0]      rdata,
	output logic             dac_clock_en,
	output logic             filter_clock_en,
	output logic             transition_mode,
	output logic             steady_state_en
);
	// ************************************
	// state
	// ************************************
	// source clocks arrive as per-cycle enables, synchronous to clk
	typedef struct packed {
		dcft_cfg_t  cfg;
		logic [15:0] rdata;
		logic [1:0]  div_cnt;
		logic        dac_en;
		logic        half;
	} dcft_top_state_t;

	dcft_top_state_t st;
	dcft_top_state_t next_st;
	dcft_bus_req_t   req;
	logic            src_en;
	logic            half_en;
	logic            fclk_en;
	logic            tm;
	logic            ss;
	logic [9:0]      elapsed;

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	always_comb begin
		unique case (st.cfg.source_select)
			DCFT_SRC_PLL:      src_en = pll_output_clock;
			DCFT_SRC_VCO_DIV3: src_en = vco_div3_clock;
			DCFT_SRC_VCO_DIV2: src_en = vco_div2_clock;
			DCFT_SRC_VCO_DIVR: src_en = vco_divider_clock;
		endcase
	end

	// filter path halves the selected source before its divider
	assign half_en = src_en && st.half;

	always_comb begin
		next_st = st;
		next_st.rdata = 16'h0000;
		next_st.dac_en = 1'b0;
		// ************************************
		// dac clock divider
		// ************************************
		if (src_en) begin
			next_st.half = ~st.half;
			unique case (st.cfg.divider)
				DCFT_DIV_2: begin
					next_st.div_cnt = {1'b0, ~st.div_cnt[0]};
					next_st.dac_en  = st.div_cnt[0];
				end
				DCFT_DIV_3, 2'h3: begin
					// uneven duty: pulse on one of three edges
					next_st.div_cnt = (st.div_cnt >= 2'h2) ? 2'h0 : st.div_cnt + 2'h1;
					next_st.dac_en  = (st.div_cnt == 2'h2);
				end
				default: begin
					next_st.div_cnt = 2'h0;
					next_st.dac_en  = 1'b1;
				end
			endcase
		end
		// ************************************
		// register writes
		// ************************************
		if (req.wr) begin
			unique case (req.addr)
				DCFT_ADDR_CLOCK_CONFIG: begin
					next_st.cfg.source_select  = req.wdata[DCFT_SRC_POS +: 2];
					next_st.cfg.divider        = req.wdata[DCFT_DIV_POS +: 2];
					next_st.cfg.filter_divider = req.wdata[DCFT_FDIV_POS +: 3];
				end
				DCFT_ADDR_STEADY_STATE: begin
					next_st.cfg.steady_state_delay = req.wdata[DCFT_TIME_W-1:0];
				end
				DCFT_ADDR_TRANSITION: begin
					next_st.cfg.transition_duration = req.wdata[DCFT_TIME_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// ************************************
		// register reads
		// ************************************
		if (req.rd) begin
			unique case (req.addr)
				DCFT_ADDR_CLOCK_CONFIG: begin
					next_st.rdata = {8'h00, st.cfg.source_select, st.cfg.divider,
						1'b0, st.cfg.filter_divider} & DCFT_CLOCK_CONFIG_MASK;
				end
				DCFT_ADDR_STEADY_STATE: begin
					next_st.rdata = {6'h00, st.cfg.steady_state_delay} & DCFT_TIME_MASK;
				end
				DCFT_ADDR_TRANSITION: begin
					next_st.rdata = {6'h00, st.cfg.transition_duration} & DCFT_TIME_MASK;
				end
				DCFT_ADDR_STATUS: begin
					next_st.rdata = {4'h0, ss, tm, elapsed};
				end
				default: begin
					next_st.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st.cfg.source_select       <= DCFT_CLOCK_CONFIG_RST[DCFT_SRC_POS +: 2];
			st.cfg.divider             <= DCFT_CLOCK_CONFIG_RST[DCFT_DIV_POS +: 2];
			st.cfg.filter_divider      <= DCFT_CLOCK_CONFIG_RST[DCFT_FDIV_POS +: 3];
			st.cfg.steady_state_delay  <= DCFT_STEADY_STATE_RST;
			st.cfg.transition_duration <= DCFT_TRANSITION_RST;
			st.rdata                   <= 16'h0000;
			st.div_cnt                 <= 2'h0;
			st.dac_en                  <= 1'b0;
			st.half                    <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	dcft_divider u_fdiv (
		.clk      (clk),
		.rst_n    (rst_n),
		.en_in    (half_en),
		.ratio_m1 (dcft_fdiv_ratio(st.cfg.filter_divider)),
		.en_out   (fclk_en)
	);

	// sequencer timed by the divided dac clock
	dcft_filter_seq u_seq (
		.clk                 (clk),
		.rst_n               (rst_n),
		.tick                (st.dac_en),
		.start               (filter_start),
		.steady_state_delay  (st.cfg.steady_state_delay),
		.transition_duration (st.cfg.transition_duration),
		.transition_mode     (tm),
		.steady_state_en     (ss),
		.elapsed             (elapsed)
	);

	assign rdata           = st.rdata;
	assign dac_clock_en    = st.dac_en;
	assign filter_clock_en = fclk_en;
	assign transition_mode = tm;
	assign steady_state_en = ss;
endmodule : dcft_top
`default_nettype wire

// file: verification/dcft_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checker
// ****************
module dcft_checker
	import dcft_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        pll_output_clock,
	input wire logic        vco_div3_clock,
	input wire logic        vco_div2_clock,
	input wire logic        vco_divider_clock,
	input wire logic        filter_start,
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        dac_clock_en,
	input wire logic        filter_clock_en,
	input wire logic        transition_mode,
	input wire logic        steady_state_en
);
	logic [3:0] cfg;
	logic [3:0] srcs;
	logic       sel;
	assign srcs = {pll_output_clock, vco_div3_clock, vco_div2_clock, vco_divider_clock};
	assign sel = srcs[cfg[3:2]];
	// shadow of source select and divider, taken from the write strobe
	always_ff @(posedge clk) begin
		if (!rst_n)
			cfg <= 4'h0;
		else if (wr && addr == DCFT_ADDR_CLOCK_CONFIG)
			cfg <= wdata[7:4];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	src_path_a:
		assert property (rst_n && cfg[1:0] == DCFT_DIV_1X |=> dac_clock_en == $past(sel))
		else $error("dac clock does not follow source");
	div_gap_a:
		assert property (cfg[1:0] != DCFT_DIV_1X && $past(cfg, 2) == cfg && dac_clock_en
			|=> !dac_clock_en)
		else $error("divided dac clock pulses twice in a row");
	filt_gap_a:
		assert property (filter_clock_en |=> !filter_clock_en)
		else $error("filter clock not halved");
	upper_zero_a:
		assert property (rd && (addr == DCFT_ADDR_STEADY_STATE || addr == DCFT_ADDR_TRANSITION)
			|=> rdata[15:10] == 6'h00)
		else $error("upper time bits not zero");
	trans_start_a:
		assert property (filter_start |=> transition_mode)
		else $error("transition mode not entered");
	steady_clr_a:
		assert property (filter_start |=> !steady_state_en)
		else $error("steady filter not cleared on start");
endmodule : dcft_checker
`default_nettype wire

// file: verification/dcft_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// bench
// ****************
module dcft_top_tb
	import dcft_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n, filter_start, wr, rd, hold;
	logic        pll_output_clock, vco_div3_clock, vco_div2_clock, vco_divider_clock;
	logic        dac_clock_en, filter_clock_en, transition_mode, steady_state_en;
	logic [3:0]  addr, a, rn;
	logic [15:0] wdata, rdata, q;
	logic [1:0]  hs;
	logic [31:0] rs = 32'h00001075;
	int          num_errors, n_checks, dc, fc, te, c, k;

	dcft_top i_dcft_top (.clk, .rst_n, .pll_output_clock, .vco_div3_clock, .vco_div2_clock,
		.vco_divider_clock, .filter_start, .addr, .wdata, .wr, .rd, .rdata, .dac_clock_en,
		.filter_clock_en, .transition_mode, .steady_state_en);

	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs

	task chk(string n, logic [15:0] e, logic [15:0] v);
		n_checks++;
		if (v !== e) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, v);
		end
	endtask : chk

	task chk_rng(string n, int lo, int hi, int v);
		n_checks++;
		if (v < lo || v > hi) begin
			num_errors++;
			$display("wrong value %s exp %0d..%0d got %0d", n, lo, hi, v);
		end
	endtask : chk_rng

	task wr_reg(logic [3:0] ad, logic [15:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task rd_chk(logic [3:0] ad, logic [15:0] e);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask : rd_chk

	task run_seq(int t, int s);
		wr_reg(DCFT_ADDR_TRANSITION, 16'(t));
		wr_reg(DCFT_ADDR_STEADY_STATE, 16'(s));
		@(posedge clk) filter_start <= 1'b1;
		@(posedge clk) filter_start <= 1'b0;
		te = -1;
		c = 0;
		repeat (1100) begin
			@(negedge clk);
			if (te < 0 && !transition_mode)
				te = c;
			if (steady_state_en === 1'b1)
				break;
			c++;
		end
		chk_rng("trans_len", (t == 0) ? 1 : t, (t == 0) ? 1 : t, te);
		chk_rng("steady_at", s, s, c);
		rd_chk(DCFT_ADDR_STATUS, {4'h0, 2'b10, 10'(s)});
	endtask : run_seq

	task test_done();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	initial forever #20 clk = ~clk;

	// selected source held high so pulse counts are exact; others stay noisy
	always @(posedge clk) begin
		rn = 4'(xs());
		{pll_output_clock, vco_div3_clock, vco_div2_clock, vco_divider_clock} <=
			rn | ({3'b000, hold} << hs);
	end

	initial begin
		{rst_n, filter_start, wr, rd, hold, addr, wdata, hs} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(DCFT_ADDR_CLOCK_CONFIG, 16'h0000);
		rd_chk(DCFT_ADDR_STEADY_STATE, 16'h008a);
		rd_chk(DCFT_ADDR_TRANSITION, 16'h0055);
		rd_chk(4'h2, 16'h0000);
		repeat (8) begin
			a = 4'(xs() % 3) << 2;
			q = 16'(xs());
			wr_reg(a, q);
			rd_chk(a, q & (a == 4'h0 ? DCFT_CLOCK_CONFIG_MASK : DCFT_TIME_MASK));
		end
		$display("test registers done");
		hold = 1'b1;
		for (int i = 0; i < 16; i++) begin
			hs = 2'(i);
			k = (i / 4 == 3) ? 3 : i / 4 + 1;
			wr_reg(DCFT_ADDR_CLOCK_CONFIG, {8'h00, 2'(i), 2'(i / 4), 1'b0, 3'(i)});
			repeat (4) @(posedge clk);
			dc = 0;
			fc = 0;
			repeat (240) begin
				@(negedge clk);
				dc += dac_clock_en;
				fc += filter_clock_en;
			end
			chk_rng("dac_clk", 240 / k - 1, 240 / k + 1, dc);
			chk_rng("filt_clk", 120 / (i % 8 + 1) - 1, 120 / (i % 8 + 1) + 1, fc);
		end
		$display("test clocks done");
		hs = 2'h0;
		wr_reg(DCFT_ADDR_CLOCK_CONFIG, 16'h0000);
		run_seq(0, 1);
		run_seq(3, 7);
		run_seq(1022, 1023);
		repeat (2) begin
			k = 32'(xs() % 40);
			run_seq(k, k + 1 + 32'(xs() % 40));
		end
		$display("test filter done");
		test_done();
	end

	initial begin
		#2400000;
		num_errors++;
		test_done();
	end
endmodule : dcft_top_tb

bind dcft_top dcft_checker i_dcft_checker (.clk, .rst_n, .pll_output_clock, .vco_div3_clock,
	.vco_div2_clock, .vco_divider_clock, .filter_start, .addr, .wdata, .wr, .rd, .rdata,
	.dac_clock_en, .filter_clock_en, .transition_mode, .steady_state_en);
`default_nettype wire
